// ===== serial_display_poll_timeout.sv
// Value conditioning, display and string timeouts, wind view and poll
// transmitter of a serial-input numeric display, with an APB slave.
// Assumes a parser upstream that strobes characters and finished values,
// and a UART downstream that takes poll bytes on a valid/ready handshake.
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
module serial_display_poll_timeout #(
	parameter int TICK_CYC = disp_pkg::TICK_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rxChar,
	input  wire logic        rxEnd,
	input  wire logic        rxErr,
	input  wire logic        rxIsCalc,
	input  wire logic [31:0] rxValue,
	input  wire logic [15:0] windDir,
	input  wire logic [15:0] windSpeed,
	input  wire logic        btnUp,
	input  wire logic        btnDown,
	output logic      [31:0] dispValue,
	output logic             dispBlank,
	output logic      [1:0]  dispLabel,
	output logic             dispError,
	output logic             stringDiscard,
	output logic      [7:0]  stationAddr,
	output logic             txValid,
	output logic      [7:0]  txData,
	input  wire logic        txReady
);
	typedef struct packed {
		logic [1:0]       mode;
		logic [1:0]       pol;
		logic             errEn;
		logic             inEn;
		logic             calcUsed;
		logic             pollEn;
		logic [1:0]       unit;
		logic [1:0]       view;
		logic [7:0]       addr;
		logic [9:0]       dsTo;
		logic [6:0]       chTo;
		logic [6:0]       pInt;
		logic [7:0]       hold;
		logic [7:0][8:0]  pch;
		logic [31:0]      rdata;
		logic             slverr;
		logic [24:0]      tbCnt;
		logic             tick;
		logic [15:0]      dsCnt;
		logic [15:0]      gap;
		logic             inStr;
		logic             drop;
		logic             discard;
		logic [15:0]      dropCnt;
		logic [31:0]      value;
		logic             haveVal;
		logic             errShow;
		logic             showSpd;
		logic             ovr;
		logic [7:0]       ovrCnt;
		logic [15:0]      scanCnt;
		logic [31:0]      disp;
		disp_pkg::poll_e  pst;
		logic [2:0]       idx;
		logic [6:0]       pCnt;
	} state_s;
	state_s s_q;
	state_s s_d;
	logic        wrEn;
	logic        rdEn;
	logic        pchHit;
	logic [31:0] clamped;
	logic [9:0]  kUnit;
	logic [25:0] spdScaled;
	logic [15:0] dsLimit;
	logic [15:0] holdLimit;
	logic        accept;
	logic        blankNow;
	logic        advance;
	logic        slotSkip;
	assign wrEn = psel & penable & pwrite;
	assign rdEn = psel & ~penable & ~pwrite;
	assign pchHit = paddr >= disp_pkg::OFF_PCH
		&& paddr <= disp_pkg::OFF_PEND && paddr[1:0] == 2'h0;
	assign dsLimit = 16'(s_q.dsTo * disp_pkg::TICKS_PER_S);
	assign holdLimit = 16'(s_q.hold * disp_pkg::TICKS_PER_S);
	assign slotSkip = s_q.pch[s_q.idx][8];
	// Polarity stage, numeric mode only
	always_comb begin
		clamped = rxValue;
		if (s_q.mode == disp_pkg::MODE_NUM) begin
			unique case (disp_pkg::pol_e'(s_q.pol))
				disp_pkg::POL_BOTH: clamped = rxValue;
				disp_pkg::POL_POS: clamped = rxValue[31] ? '0 : rxValue;
				disp_pkg::POL_NEG: clamped = rxValue[31] ? rxValue : '0;
				disp_pkg::POL_ABS: clamped = rxValue[31] ? -rxValue : rxValue;
			endcase
		end
	end
	always_comb begin
		unique case (s_q.unit)
			2'h0: kUnit = disp_pkg::K_MS;
			2'h1: kUnit = disp_pkg::K_KMH;
			2'h2: kUnit = disp_pkg::K_MPH;
			2'h3: kUnit = disp_pkg::K_KN;
		endcase
		spdScaled = windSpeed * kUnit;
	end
	// raw channels suppressed when calc results are wanted and inEn is clear
	assign accept = rxEnd & ~s_q.drop & ~rxErr
		& ~(s_q.calcUsed & ~s_q.inEn & ~rxIsCalc);
	// blank once the validity window runs out
	assign blankNow = s_q.dsTo != '0 && s_q.dsCnt >= dsLimit;
	assign advance = s_q.pst == disp_pkg::P_SEND
		&& (slotSkip || txReady);
	always_comb begin
		s_d = s_q;
		s_d.discard = 1'b0;
		s_d.tick = 1'b0;
		if (s_q.tbCnt >= 25'(TICK_CYC - 1)) begin
			s_d.tbCnt = '0;
			s_d.tick = 1'b1;
		end else begin
			s_d.tbCnt = s_q.tbCnt + 25'h1;
		end
		// APB read data latched in setup so the access phase needs no wait
		if (rdEn) begin
			s_d.rdata = '0;
			s_d.slverr = 1'b0;
			if (pchHit) begin
				s_d.rdata[8:0] = s_q.pch[paddr[4:2]];
			end else begin
				unique case (paddr)
					disp_pkg::OFF_CTRL: s_d.rdata[11:0] = {s_q.view,
						s_q.unit, s_q.pollEn, s_q.calcUsed, s_q.inEn,
						s_q.errEn, s_q.pol, s_q.mode};
					disp_pkg::OFF_ADDR: s_d.rdata[7:0] = s_q.addr;
					disp_pkg::OFF_DSTO: s_d.rdata[9:0] = s_q.dsTo;
					disp_pkg::OFF_CHTO: s_d.rdata[6:0] = s_q.chTo;
					disp_pkg::OFF_PINT: s_d.rdata[6:0] = s_q.pInt;
					disp_pkg::OFF_HOLD: s_d.rdata[7:0] = s_q.hold;
					disp_pkg::OFF_STAT: s_d.rdata = {s_q.dropCnt, 11'h000,
						s_q.inStr, s_q.pst != disp_pkg::P_IDLE, s_q.errShow,
						s_q.showSpd, blankNow | ~s_q.haveVal};
					disp_pkg::OFF_VAL: s_d.rdata = s_q.disp;
					default: s_d.slverr = 1'b1;
				endcase
			end
		end else if (psel & ~penable) begin
			s_d.slverr = ~pchHit && paddr != disp_pkg::OFF_CTRL
				&& paddr != disp_pkg::OFF_ADDR
				&& paddr != disp_pkg::OFF_DSTO
				&& paddr != disp_pkg::OFF_CHTO
				&& paddr != disp_pkg::OFF_PINT
				&& paddr != disp_pkg::OFF_HOLD;
		end
		if (wrEn && !s_q.slverr) begin
			if (pchHit) begin
				// bit 8 set means skip the slot
				s_d.pch[paddr[4:2]] = pwdata[8:0];
			end else begin
				unique case (paddr)
					disp_pkg::OFF_CTRL: begin
						s_d.mode = pwdata[disp_pkg::C_MODE+:2];
						s_d.pol = pwdata[disp_pkg::C_POL+:2];
						s_d.errEn = pwdata[disp_pkg::C_ERR];
						s_d.inEn = pwdata[disp_pkg::C_INCH];
						s_d.calcUsed = pwdata[disp_pkg::C_CALC];
						s_d.pollEn = pwdata[disp_pkg::C_POLL];
						s_d.unit = pwdata[disp_pkg::C_UNIT+:2];
						s_d.view = pwdata[disp_pkg::C_VIEW+:2];
					end
					disp_pkg::OFF_ADDR: s_d.addr = pwdata[7:0];
					// capped at the top of the range
					disp_pkg::OFF_DSTO: s_d.dsTo =
						pwdata[31:10] != '0
						|| pwdata[9:0] > disp_pkg::MAX_DSTO
						? disp_pkg::MAX_DSTO : pwdata[9:0];
					// 0.1 to 10.0 s in tenths
					disp_pkg::OFF_CHTO: s_d.chTo =
						pwdata[31:7] != '0
						|| pwdata[6:0] > disp_pkg::MAX_TENTH
						? disp_pkg::MAX_TENTH
						: (pwdata[6:0] < disp_pkg::MIN_CHTO
						? disp_pkg::MIN_CHTO : pwdata[6:0]);
					// 0.0 to 10.0 s in tenths
					disp_pkg::OFF_PINT: s_d.pInt =
						pwdata[31:7] != '0
						|| pwdata[6:0] > disp_pkg::MAX_TENTH
						? disp_pkg::MAX_TENTH : pwdata[6:0];
					disp_pkg::OFF_HOLD: s_d.hold =
						pwdata[31:8] != '0
						|| pwdata[7:0] > disp_pkg::MAX_HOLD
						? disp_pkg::MAX_HOLD : pwdata[7:0];
					default: s_d.hold = s_q.hold;
				endcase
			end
		end
		// gap watchdog over the string in progress
		if (rxChar) begin
			s_d.gap = '0;
			s_d.inStr = 1'b1;
		end else if (s_q.inStr && s_q.tick) begin
			if (s_q.gap >= 16'(s_q.chTo)) begin
				s_d.inStr = 1'b0;
				s_d.drop = 1'b1;
				s_d.discard = 1'b1;
				s_d.dropCnt = s_q.dropCnt + 16'h1;
			end else begin
				s_d.gap = s_q.gap + 16'h1;
			end
		end
		if (rxEnd) begin
			s_d.inStr = 1'b0;
			s_d.drop = 1'b0;
		end
		// counter runs from the last good value
		if (accept) begin
			s_d.value = clamped;
			s_d.haveVal = 1'b1;
			s_d.dsCnt = '0;
			s_d.errShow = 1'b0;
		end else if (s_q.tick && s_q.dsCnt != '1) begin
			s_d.dsCnt = s_q.dsCnt + 16'h1;
		end
		// error text only with messages enabled
		if (rxEnd && !s_q.drop && rxErr) begin
			s_d.errShow = s_q.errEn;
		end
		// scan alternates at the hold time
		if (s_q.ovr) begin
			if (s_q.tick) begin
				s_d.ovrCnt = s_q.ovrCnt + 8'h1;
				if (s_q.ovrCnt + 8'h1 >= disp_pkg::REVERT_TICKS) begin
					s_d.ovr = 1'b0;
					s_d.scanCnt = '0;
					if (s_q.view != disp_pkg::VIEW_SCAN) begin
						s_d.showSpd = s_q.view == disp_pkg::VIEW_SPD;
					end
				end
			end
		end else if (s_q.view == disp_pkg::VIEW_SCAN) begin
			if (s_q.tick) begin
				if (s_q.scanCnt + 16'h1 >= holdLimit) begin
					s_d.scanCnt = '0;
					s_d.showSpd = ~s_q.showSpd;
				end else begin
					s_d.scanCnt = s_q.scanCnt + 16'h1;
				end
			end
		end else begin
			s_d.showSpd = s_q.view == disp_pkg::VIEW_SPD;
		end
		if (s_q.mode == disp_pkg::MODE_WIND && (btnUp || btnDown)) begin
			s_d.showSpd = ~s_q.showSpd;
			s_d.ovr = 1'b1;
			s_d.ovrCnt = '0;
		end
		if (s_q.mode == disp_pkg::MODE_WIND) begin
			s_d.disp = s_q.showSpd ? 32'(spdScaled[25:8])
				: 32'(windDir);
		end else begin
			s_d.disp = s_q.value;
		end

		unique case (s_q.pst)
			disp_pkg::P_IDLE: begin
				s_d.idx = '0;
				s_d.pst = disp_pkg::P_SEND;
			end
			disp_pkg::P_SEND: begin
				if (advance) begin
					s_d.idx = s_q.idx + 3'h1;
					if (s_q.idx == 3'h7) begin
						s_d.pCnt = '0;
						s_d.pst = s_q.pInt == '0 ? disp_pkg::P_SEND
							: disp_pkg::P_WAIT;
					end
				end
			end
			disp_pkg::P_WAIT: begin
				if (s_q.tick) begin
					s_d.pCnt = s_q.pCnt + 7'h1;
					if (s_q.pCnt + 7'h1 >= s_q.pInt) begin
						s_d.pst = disp_pkg::P_SEND;
					end
				end
			end
		endcase
		// polling only when enabled in numeric mode
		if (!s_q.pollEn || s_q.mode != disp_pkg::MODE_NUM) begin
			s_d.pst = disp_pkg::P_IDLE;
		end

		if (!rstn) begin
			s_d = '0;
			s_d.addr = disp_pkg::RST_ADDR;
			s_d.dsTo = disp_pkg::RST_DSTO;
			s_d.chTo = disp_pkg::RST_TENTH;
			s_d.pInt = disp_pkg::RST_TENTH;
			s_d.hold = disp_pkg::RST_HOLD;
			s_d.errEn = 1'b1;
			s_d.inEn = 1'b1;
			s_d.pch = {8{disp_pkg::PCH_SKIP}};
			s_d.pst = disp_pkg::P_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		s_q <= s_d;
	end

	assign prdata = s_q.rdata;
	assign pready = 1'b1;
	assign pslverr = psel & penable & s_q.slverr;
	assign dispValue = s_q.disp;
	assign dispBlank = blankNow | ~s_q.haveVal;
	assign dispError = s_q.errShow;
	assign stringDiscard = s_q.discard;
	assign stationAddr = s_q.addr;
	assign dispLabel = s_q.mode != disp_pkg::MODE_WIND
		|| s_q.view != disp_pkg::VIEW_SCAN || s_q.ovr ? disp_pkg::LBL_NONE
		: (s_q.showSpd ? disp_pkg::LBL_SPD : disp_pkg::LBL_DIR);
	// skipped slots never reach the line
	assign txValid = s_q.pst == disp_pkg::P_SEND && !slotSkip;
	assign txData = s_q.pch[s_q.idx][7:0];
endmodule // serial_display_poll_timeout

// ===== disp_pkg.sv
// Constants, types and register map of the serial display conditioner.
// Assumes one 250 MHz clock and an APB master with 32-bit data.
package disp_pkg;
	// Clock and timebase
	localparam int CLK_PERIOD_NS = 4;
	localparam int TICK_MS       = 100;
	localparam int TICK_CYCLES   = TICK_MS * 1000000 / CLK_PERIOD_NS;
	localparam int TICKS_PER_S   = 1000 / TICK_MS;
	localparam int WIND_REVERT_S = 4;
	localparam logic [7:0] REVERT_TICKS = 8'(WIND_REVERT_S * TICKS_PER_S);

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_ADDR = 8'h04;
	localparam logic [7:0] OFF_DSTO = 8'h08;
	localparam logic [7:0] OFF_CHTO = 8'h0c;
	localparam logic [7:0] OFF_PINT = 8'h10;
	localparam logic [7:0] OFF_HOLD = 8'h14;
	localparam logic [7:0] OFF_STAT = 8'h18;
	localparam logic [7:0] OFF_VAL  = 8'h1c;
	localparam logic [7:0] OFF_PCH  = 8'h20;
	localparam logic [7:0] OFF_PEND = 8'h3c;

	// Control field positions
	localparam int C_MODE = 0;
	localparam int C_POL  = 2;
	localparam int C_ERR  = 4;
	localparam int C_INCH = 5;
	localparam int C_CALC = 6;
	localparam int C_POLL = 7;
	localparam int C_UNIT = 8;
	localparam int C_VIEW = 10;

	// Reset values and limits
	localparam logic [7:0] RST_ADDR = 8'h01;
	localparam logic [9:0] RST_DSTO = 10'h00a;
	localparam logic [9:0] MAX_DSTO = 10'h3e8;
	localparam logic [6:0] RST_TENTH = 7'h0a;
	localparam logic [6:0] MIN_CHTO  = 7'h01;
	localparam logic [6:0] MAX_TENTH = 7'h64;
	localparam logic [7:0] RST_HOLD = 8'h0a;
	localparam logic [7:0] MAX_HOLD = 8'hc8;
	localparam logic [8:0] PCH_SKIP = 9'h1ff;

	// Speed scale factors, 8 fractional bits
	localparam logic [9:0] K_MS  = 10'h100;
	localparam logic [9:0] K_KMH = 10'h39a;
	localparam logic [9:0] K_MPH = 10'h23d;
	localparam logic [9:0] K_KN  = 10'h1f2;

	typedef enum logic [1:0] {
		MODE_NUM = 2'h0, MODE_WIND = 2'h1, MODE_REG = 2'h2
	} mode_e;
	typedef enum logic [1:0] {
		POL_BOTH = 2'h0, POL_POS = 2'h1, POL_NEG = 2'h2, POL_ABS = 2'h3
	} pol_e;
	typedef enum logic [1:0] {
		VIEW_SCAN = 2'h0, VIEW_DIR = 2'h1, VIEW_SPD = 2'h2
	} view_e;
	typedef enum logic [1:0] {
		LBL_NONE = 2'h0, LBL_DIR = 2'h1, LBL_SPD = 2'h2
	} label_e;
	typedef enum logic [2:0] {
		P_IDLE = 3'h1, P_SEND = 3'h2, P_WAIT = 3'h4
	} poll_e;
endpackage

// ===== disp_checker.sv
// Port assertions for the serial display conditioner.
// Bound to serial_display_poll_timeout; shadows CTRL from APB writes.
`timescale 1ns/1ns
module disp_checker (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        rxEnd,
	input wire logic        rxErr,
	input wire logic [31:0] rxValue,
	input wire logic [31:0] dispValue,
	input wire logic        dispBlank,
	input wire logic        stringDiscard,
	input wire logic [7:0]  stationAddr,
	input wire logic        txValid,
	input wire logic [7:0]  txData,
	input wire logic        txReady
);
	logic [11:0] ctrlQ;
	logic        dropQ;
	logic        good;
	logic        wr;
	assign wr = psel && penable && pwrite;
	assign good = rxEnd && !rxErr && !dropQ && ctrlQ[1:0] == 2'h0 && ctrlQ[5];
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ctrlQ <= 12'h030;
			dropQ <= 1'b0;
		end else begin
			if (wr && paddr == 8'h00)
				ctrlQ <= pwdata[11:0];
			if (stringDiscard)
				dropQ <= 1'b1;
			else if (rxEnd)
				dropQ <= 1'b0;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	both_pass_a:
		assert property (good && ctrlQ[3:2] == 2'h0
			|-> ##2 dispValue == $past(rxValue, 2)) else $error("value altered");
	pos_clamp_a:
		assert property (good && ctrlQ[3:2] == 2'h1 && rxValue[31]
			|-> ##2 dispValue == 32'h0) else $error("negative shown");
	neg_clamp_a:
		assert property (good && ctrlQ[3:2] == 2'h2 && !rxValue[31]
			|-> ##2 dispValue == 32'h0) else $error("positive shown");
	abs_value_a:
		assert property (good && ctrlQ[3:2] == 2'h3 |-> ##2 !dispValue[31]
			&& (dispValue == $past(rxValue, 2) || dispValue == -$past(rxValue, 2)))
			else $error("magnitude wrong");
	station_addr_a:
		assert property (wr && paddr == 8'h04
			|=> stationAddr == $past(pwdata[7:0])) else $error("address not set");
	blank_clear_a:
		assert property (good |=> !dispBlank) else $error("still blank");
	discard_pulse_a:
		assert property (stringDiscard |=> !stringDiscard) else $error("long pulse");
	tx_hold_a:
		assert property (txValid && !txReady && !wr
			|=> txValid && $stable(txData)) else $error("byte dropped");
	poll_off_a:
		assert property (!ctrlQ[7] [*3] |-> !txValid) else $error("poll while off");
	apb_ready_a:
		assert property (psel && penable |-> pready) else $error("no ready");
	slverr_idle_a:
		assert property (!(psel && penable) |-> !pslverr) else $error("stray error");
	cover property (txValid && txReady);
	cover property (stringDiscard);
	cover property ($rose(dispBlank));
endmodule // disp_checker

bind serial_display_poll_timeout disp_checker disp_checker_inst (
	.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
	.pslverr, .rxEnd, .rxErr, .rxValue, .dispValue, .dispBlank,
	.stringDiscard, .stationAddr, .txValid, .txData, .txReady
);

// ===== remote_model.sv
// Remote instrument: sends parsed strings, takes poll bytes.
// Driven by testbench task calls; slow makes it stall every other cycle.
`timescale 1ns/1ns
module remote_model (
	input  wire logic        clk,
	input  wire logic        slow,
	output logic             rxChar,
	output logic             rxEnd,
	output logic             rxErr,
	output logic             rxIsCalc,
	output logic      [31:0] rxValue,
	input  wire logic        txValid,
	input  wire logic [7:0]  txData,
	output logic             txReady
);
	logic [7:0] got[$];
	initial begin
		rxChar = 1'b0;
		rxEnd = 1'b0;
		rxErr = 1'b0;
		rxIsCalc = 1'b0;
		rxValue = 32'h0;
		txReady = 1'b0;
	end
	task automatic pulse(input logic c, input logic e, input logic er,
		input logic k, input logic [31:0] v);
		@(posedge clk);
		rxChar <= c;
		rxEnd <= e;
		rxErr <= er;
		rxIsCalc <= k;
		rxValue <= v;
		@(posedge clk);
		rxChar <= 1'b0;
		rxEnd <= 1'b0;
		rxErr <= 1'b0;
		// Value is not held once the string is over
		rxValue <= ~v;
	endtask
	always @(posedge clk) begin
		if (txValid && txReady)
			got.push_back(txData);
		txReady <= slow ? ~txReady : 1'b1;
	end
endmodule // remote_model

// ===== testbench.sv
// Self-checking bench for the display conditioner over APB.
// remote_model is the far side; timebase shortened to 10 cycles a tick.
`timescale 1ns/1ns
module testbench;
	logic        clk;
	logic        rstn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rxChar;
	logic        rxEnd;
	logic        rxErr;
	logic        rxIsCalc;
	logic [31:0] rxValue;
	logic [31:0] dispValue;
	logic        dispBlank;
	logic [1:0]  dispLabel;
	logic        dispError;
	logic        stringDiscard;
	logic [7:0]  stationAddr;
	logic        txValid;
	logic [7:0]  txData;
	logic        txReady;
	logic        slow;
	logic [15:0] windDir;
	logic [15:0] windSpeed;
	logic        btnUp;
	logic        btnDown;
	logic [1:0]  lbl;
	logic [31:0] rdata;
	logic        perr;
	logic [31:0] e;
	int          err_count;
	int          tests_run;
	int          cyc = 0;
	logic [7:0]  ra[6] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
	logic [31:0] rv[6] = '{32'h1, 32'ha, 32'ha, 32'ha, 32'ha, 32'h1ff};

	serial_display_poll_timeout #(.TICK_CYC(10))
		serial_display_poll_timeout_inst (
		.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .rxChar, .rxEnd, .rxErr, .rxIsCalc, .rxValue,
		.windDir, .windSpeed, .btnUp, .btnDown,
		.dispValue, .dispBlank, .dispLabel, .dispError, .stringDiscard,
		.stationAddr, .txValid, .txData, .txReady
	);
	remote_model remote_model_inst (
		.clk, .slow, .rxChar, .rxEnd, .rxErr, .rxIsCalc, .rxValue,
		.txValid, .txData, .txReady
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rdata = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic give_verdict();
		$display("comparisons=%0d mismatches=%0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Hang guard, well above the roughly 1500 cycles needed
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			give_verdict();
		end
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata, slow, rstn} = '0;
		{btnUp, btnDown} = 2'h0;
		windDir = 16'h00b4;
		windSpeed = 16'h000a;
		err_count = 0;
		tests_run = 0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		apb(0, disp_pkg::OFF_CTRL, 0);
		check(rdata, 32'h30);
		for (int i = 0; i < 6; i++) begin
			apb(0, ra[i], 0);
			check(rdata, rv[i]);
		end
		check(stationAddr, 8'h01);
		apb(1, disp_pkg::OFF_ADDR, 32'hff);
		// Write lands at the access edge; look one cycle on
		@(posedge clk);
		check(stationAddr, 8'hff);
		apb(1, disp_pkg::OFF_DSTO, 32'hfff);
		apb(0, disp_pkg::OFF_DSTO, 0);
		check(rdata, 32'd1000);
		apb(1, disp_pkg::OFF_PINT, 32'hff);
		apb(0, disp_pkg::OFF_PINT, 0);
		check(rdata, 32'd100);
		apb(1, disp_pkg::OFF_HOLD, 32'hff);
		apb(0, disp_pkg::OFF_HOLD, 0);
		check(rdata, 32'd200);
		apb(0, 8'h40, 0);
		check(perr, 1'b1);
		apb(1, disp_pkg::OFF_VAL, 32'h5);
		check(perr, 1'b1);
		$display("registers done");
		for (int p = 0; p < 4; p++) begin
			apb(1, disp_pkg::OFF_CTRL, 32'h30 | 32'(p << 2));
			for (int s = -5; s <= 5; s += 10) begin
				remote_model_inst.pulse(1, 1, 0, 0, 32'(s));
				repeat (3) @(posedge clk);
				e = 32'(s);
				if ((p == 1 && s < 0) || (p == 2 && s > 0))
					e = 0;
				if (p == 3 && s < 0)
					e = 32'(-s);
				check(dispValue, e);
			end
		end
		$display("polarity done");
		apb(1, disp_pkg::OFF_DSTO, 32'h1);
		remote_model_inst.pulse(1, 1, 0, 0, 32'h7);
		repeat (20) @(posedge clk);
		check(dispBlank, 1'b0);
		repeat (110) @(posedge clk);
		check(dispBlank, 1'b1);
		apb(1, disp_pkg::OFF_DSTO, 32'h0);
		remote_model_inst.pulse(1, 1, 0, 0, 32'h3);
		repeat (150) @(posedge clk);
		check(dispBlank, 1'b0);
		$display("timeout done");
		apb(1, disp_pkg::OFF_CHTO, 32'h1);
		remote_model_inst.pulse(1, 0, 0, 0, 32'h0);
		for (int i = 0; i < 40 && stringDiscard !== 1'b1; i++)
			@(posedge clk);
		check(stringDiscard, 1'b1);
		remote_model_inst.pulse(0, 1, 0, 0, 32'h63);
		repeat (3) @(posedge clk);
		check(dispValue, 32'h3);
		apb(1, disp_pkg::OFF_CHTO, 32'ha);
		$display("gap done");
		remote_model_inst.pulse(1, 1, 1, 0, 32'h5);
		repeat (3) @(posedge clk);
		check(dispError, 1'b1);
		apb(1, disp_pkg::OFF_CTRL, 32'h20);
		remote_model_inst.pulse(1, 1, 1, 0, 32'h5);
		repeat (3) @(posedge clk);
		check(dispError, 1'b0);
		apb(1, disp_pkg::OFF_CTRL, 32'h50);
		remote_model_inst.pulse(1, 1, 0, 0, 32'hb);
		repeat (3) @(posedge clk);
		check(dispValue, 32'h3);
		remote_model_inst.pulse(1, 1, 0, 1, 32'hc);
		repeat (3) @(posedge clk);
		check(dispValue, 32'hc);
		$display("errors done");
		apb(1, 8'h20, 32'h41);
		apb(1, 8'h28, 32'h0d);
		apb(1, disp_pkg::OFF_PINT, 32'h0);
		slow <= 1'b1;
		apb(1, disp_pkg::OFF_CTRL, 32'hb0);
		repeat (200) @(posedge clk);
		apb(1, disp_pkg::OFF_CTRL, 32'h30);
		repeat (5) @(posedge clk);
		check(remote_model_inst.got[0], 8'h41);
		check(remote_model_inst.got[1], 8'h0d);
		check(remote_model_inst.got[2], 8'h41);
		remote_model_inst.got.delete();
		repeat (200) @(posedge clk);
		check(remote_model_inst.got.size(), 0);
		$display("poll done");
		// Hold 1 s is 100 cycles: exactly one scan toggle per window
		apb(1, disp_pkg::OFF_HOLD, 32'h1);
		apb(1, disp_pkg::OFF_CTRL, 32'h131);
		repeat (5) @(posedge clk);
		lbl = dispLabel;
		@(posedge clk);
		e = lbl == 2'h1 ? 32'd180 : 32'd36;
		check(dispValue, e);
		repeat (99) @(posedge clk);
		check(dispLabel, 2'h3 - lbl);
		// Speed view in knots, 10 m/s shows 19
		apb(1, disp_pkg::OFF_CTRL, 32'hb31);
		@(posedge clk);
		btnUp <= 1'b1;
		@(posedge clk);
		btnUp <= 1'b0;
		repeat (5) @(posedge clk);
		check(dispValue, 32'd180);
		check(dispLabel, 2'h0);
		repeat (300) @(posedge clk);
		check(dispValue, 32'd180);
		repeat (150) @(posedge clk);
		check(dispValue, 32'd19);
		@(posedge clk);
		btnDown <= 1'b1;
		@(posedge clk);
		btnDown <= 1'b0;
		repeat (5) @(posedge clk);
		check(dispValue, 32'd180);
		$display("wind done");
		give_verdict();
	end
endmodule // testbench
